// ---- alert_mask_pkg.sv ----
// constants of the alert enable mask and accumulator source image
// How it works
// - Bits 15 down to 12 enable the overvoltage alert of channels 1 to 4, a one enabling it.
// - Bits 11 down to 8 enable the undervoltage alert of channels 1 to 4, a one enabling it.
// - Bits 7 down to 4 enable the overpower alert of channels 1 to 4, a one enabling it.
// - Bit 3 gates the alert raised when any channel accumulator passes its fullness limit.
// - Bit 2 gates the alert raised when the accumulation sample counter passes its fullness limit.
// - Bit 1 gates the alert raised each time a conversion cycle completes.
// - A read-only byte shows the four 2-bit accumulator source fields in force, channel 1 on top.
// - Writes to the programmed accumulator source register only take effect at a refresh.
// - Source code 00 is power, 01 sense voltage, 10 bus voltage; 11 is reserved and reads as zero.
// - Newly written alert enables only take effect at a refresh, full or restricted.
// - An alert condition reaches the alert outputs only while its enable bit is in force.
package alert_mask_pkg;
    localparam logic [7:0] ADDR_ACCUM_SOURCE_PROG = 8'h25;
    localparam logic [7:0] ADDR_ALERT_SOURCE_ENABLE = 8'h49;
    localparam logic [7:0] ADDR_ACCUM_SOURCE_ACTIVE = 8'h4a;
    localparam int EN_WIDTH = 24;
    localparam int SRC_WIDTH = 8;
    localparam int CHANNELS = 4;
    localparam int BIT_CHAN1_OVERVOLT_ALERT_EN = 15;
    localparam int BIT_CHAN1_UNDERVOLT_ALERT_EN = 11;
    localparam int BIT_CHAN1_OVERPOWER_ALERT_EN = 7;
    localparam int BIT_ACCUM_FULL_ALERT_EN = 3;
    localparam int BIT_SAMPLE_COUNTER_FULL_ALERT_EN = 2;
    localparam int BIT_CYCLE_DONE_ALERT_EN = 1;
    // overcurrent/undercurrent bits 23:16 live elsewhere, bit 0 unimplemented
    localparam logic [23:0] EN_WRITE_MASK = 24'h00fffe;
    localparam logic [23:0] EN_RESET = 24'h000000;
    localparam logic [7:0] SRC_RESET = 8'h00;
    localparam logic [1:0] SRC_POWER = 2'h0;
    localparam logic [1:0] SRC_SENSE = 2'h1;
    localparam logic [1:0] SRC_BUS = 2'h2;
    localparam logic [1:0] SRC_RESERVED = 2'h3;
endpackage

// ---- shadow_if.sv ----
// carrier between register decode and the programmed/active shadow store
`timescale 1ns/1ps
interface shadow_if;
    logic ce;
    logic en_wr;
    logic [23:0] en_wdata;
    logic src_wr;
    logic [7:0] src_wdata;
    logic refresh;
    logic [23:0] en_prog;
    logic [23:0] en_active;
    logic [7:0] src_prog;
    logic [7:0] src_active;
    modport ctrl (output ce, en_wr, en_wdata, src_wr, src_wdata, refresh,
                  input en_prog, en_active, src_prog, src_active);
    modport store (input ce, en_wr, en_wdata, src_wr, src_wdata, refresh,
                   output en_prog, en_active, src_prog, src_active);
endinterface

// ---- shadow_store.sv ----
// programmed and active copies of the alert enables and accumulator sources
`timescale 1ns/1ps
module shadow_store
    import alert_mask_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    shadow_if.store sh
);
    logic [7:0] src_clean;

    // reserved code is stored as zero so it reads back as zero
    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++) begin : g_src
            assign src_clean[2*ch+1 -: 2] = (sh.src_wdata[2*ch+1 -: 2] == SRC_RESERVED) ?
                SRC_POWER : sh.src_wdata[2*ch+1 -: 2];
        end
    endgenerate

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            sh.en_prog <= EN_RESET;
        end else if (sh.ce && sh.en_wr) begin
            sh.en_prog <= sh.en_wdata & EN_WRITE_MASK;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            sh.src_prog <= SRC_RESET;
        end else if (sh.ce && sh.src_wr) begin
            sh.src_prog <= src_clean;
        end
    end

    // a write in the refresh cycle lands in the programmed copy only
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            sh.en_active <= EN_RESET;
            sh.src_active <= SRC_RESET;
        end else if (sh.ce && sh.refresh) begin
            sh.en_active <= sh.en_prog;
            sh.src_active <= sh.src_prog;
        end
    end
endmodule

// ---- alert_mask.sv ----
// alert source enable mask with refresh-activated shadows and register access
`timescale 1ns/1ps
module alert_mask
    import alert_mask_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire logic i_clk_en,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [23:0] i_reg_wdata,
    input wire logic i_refresh,
    input wire logic [3:0] i_overvolt_event,
    input wire logic [3:0] i_undervolt_event,
    input wire logic [3:0] i_overpower_event,
    input wire logic i_accum_full_event,
    input wire logic i_sample_counter_full_event,
    input wire logic i_cycle_done_event,
    output logic [23:0] o_reg_rdata,
    output logic o_reg_rvalid,
    output logic [3:0] o_overvolt_alert,
    output logic [3:0] o_undervolt_alert,
    output logic [3:0] o_overpower_alert,
    output logic o_accum_full_alert,
    output logic o_sample_counter_full_alert,
    output logic o_cycle_done_alert,
    output logic o_alert_any,
    output logic [7:0] o_accum_source_active
);
    shadow_if sh ();
    logic [3:0] overvolt_en;
    logic [3:0] undervolt_en;
    logic [3:0] overpower_en;
    logic [3:0] next_overvolt;
    logic [3:0] next_undervolt;
    logic [3:0] next_overpower;
    logic next_accum_full;
    logic next_sample_full;
    logic next_cycle_done;
    logic [23:0] next_rdata;

    assign sh.ce = i_clk_en;
    assign sh.en_wr = i_reg_wr && (i_reg_addr == ADDR_ALERT_SOURCE_ENABLE);
    assign sh.src_wr = i_reg_wr && (i_reg_addr == ADDR_ACCUM_SOURCE_PROG);
    assign sh.en_wdata = i_reg_wdata;
    assign sh.src_wdata = i_reg_wdata[7:0];
    assign sh.refresh = i_refresh;

    shadow_store u_store (
        .i_clk_sys(i_clk_sys),
        .i_resetn(i_resetn),
        .sh(sh.store)
    );

    // channel 1 is the most significant bit of each group
    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
            assign overvolt_en[ch] = sh.en_active[BIT_CHAN1_OVERVOLT_ALERT_EN - ch];
            assign undervolt_en[ch] = sh.en_active[BIT_CHAN1_UNDERVOLT_ALERT_EN - ch];
            assign overpower_en[ch] = sh.en_active[BIT_CHAN1_OVERPOWER_ALERT_EN - ch];
        end
    endgenerate

    // only the enables in force gate events, never the programmed copy
    always_comb begin
        next_overvolt = i_overvolt_event & overvolt_en;
        next_undervolt = i_undervolt_event & undervolt_en;
        next_overpower = i_overpower_event & overpower_en;
        next_accum_full = i_accum_full_event && sh.en_active[BIT_ACCUM_FULL_ALERT_EN];
        next_sample_full = i_sample_counter_full_event
            && sh.en_active[BIT_SAMPLE_COUNTER_FULL_ALERT_EN];
        next_cycle_done = i_cycle_done_event && sh.en_active[BIT_CYCLE_DONE_ALERT_EN];
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_overvolt_alert <= 4'h0;
            o_undervolt_alert <= 4'h0;
            o_overpower_alert <= 4'h0;
            o_accum_full_alert <= 1'b0;
            o_sample_counter_full_alert <= 1'b0;
            o_cycle_done_alert <= 1'b0;
            o_alert_any <= 1'b0;
        end else if (i_clk_en) begin
            o_overvolt_alert <= next_overvolt;
            o_undervolt_alert <= next_undervolt;
            o_overpower_alert <= next_overpower;
            o_accum_full_alert <= next_accum_full;
            o_sample_counter_full_alert <= next_sample_full;
            o_cycle_done_alert <= next_cycle_done;
            o_alert_any <= (|next_overvolt) || (|next_undervolt) || (|next_overpower)
                || next_accum_full || next_sample_full || next_cycle_done;
        end
    end

    // unmapped addresses read zero
    always_comb begin
        if (i_reg_addr == ADDR_ALERT_SOURCE_ENABLE) begin
            next_rdata = sh.en_prog;
        end else if (i_reg_addr == ADDR_ACCUM_SOURCE_PROG) begin
            next_rdata = {16'h0000, sh.src_prog};
        end else if (i_reg_addr == ADDR_ACCUM_SOURCE_ACTIVE) begin
            next_rdata = {16'h0000, sh.src_active};
        end else begin
            next_rdata = 24'h000000;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_reg_rdata <= 24'h000000;
            o_reg_rvalid <= 1'b0;
        end else if (i_clk_en) begin
            o_reg_rvalid <= i_reg_rd;
            if (i_reg_rd) begin
                o_reg_rdata <= next_rdata;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_accum_source_active <= SRC_RESET;
        end else if (i_clk_en) begin
            o_accum_source_active <= sh.src_active;
        end
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);

    sequence s_src_write;
        i_clk_en && sh.src_wr && !i_refresh;
    endsequence

    sequence s_refresh;
        i_clk_en && i_refresh && !sh.src_wr && !sh.en_wr;
    endsequence

    sequence s_quiet;
        !i_refresh && !sh.src_wr;
    endsequence

    chk_overvolt_gate: assert property (
        i_clk_en && i_overvolt_event[0] |=> o_overvolt_alert[0] == $past(sh.en_active[15]))
        else $error("overvolt alert of channel 1 not gated by bit 15");
    chk_undervolt_gate: assert property (
        i_clk_en && i_undervolt_event[3] |=> o_undervolt_alert[3] == $past(sh.en_active[8]))
        else $error("undervolt alert of channel 4 not gated by bit 8");
    chk_overpower_gate: assert property (
        i_clk_en && i_overpower_event[0] |=> o_overpower_alert[0] == $past(sh.en_active[7]))
        else $error("overpower alert of channel 1 not gated by bit 7");
    chk_accum_full_gate: assert property (
        i_clk_en && i_accum_full_event |=> o_accum_full_alert == $past(sh.en_active[3]))
        else $error("accumulator full alert not gated by bit 3");
    chk_sample_full_gate: assert property (
        i_clk_en && i_sample_counter_full_event |=> o_sample_counter_full_alert == $past(sh.en_active[2]))
        else $error("sample counter alert not gated by bit 2");
    chk_cycle_done_gate: assert property (
        i_clk_en && i_cycle_done_event |=> o_cycle_done_alert == $past(sh.en_active[1]))
        else $error("cycle done alert not gated by bit 1");
    chk_active_readback: assert property (
        i_clk_en && i_reg_rd && i_reg_addr == ADDR_ACCUM_SOURCE_ACTIVE
        |=> o_reg_rvalid && o_reg_rdata == {16'h0000, $past(sh.src_active)})
        else $error("active source image read back wrong");
    chk_write_then_refresh: assert property (
        s_src_write ##1 s_quiet ##1 s_refresh
        |=> sh.src_active == $past(sh.src_prog) && sh.src_active == $past(sh.src_prog, 2))
        else $error("programmed source did not take effect at refresh");
    chk_no_refresh_hold: assert property (
        !i_refresh |=> $stable(sh.src_active) && $stable(sh.en_active))
        else $error("active copy changed without refresh");
    chk_reserved_code: assert property (
        i_clk_en && sh.src_wr && i_reg_wdata[7:6] == 2'h3 |=> sh.src_prog[7:6] == 2'h0)
        else $error("reserved source code not cleared");
    chk_reserved_low: assert property (
        i_clk_en && sh.src_wr && i_reg_wdata[1:0] == SRC_RESERVED |=> sh.src_prog[1:0] == SRC_POWER)
        else $error("reserved source code of channel 4 not cleared");
    chk_enable_refresh: assert property (
        i_clk_en && i_refresh |=> sh.en_active == $past(sh.en_prog))
        else $error("enables not activated by refresh");
    chk_alert_needs_enable: assert property (
        $past(i_clk_en) && o_alert_any |-> $past(|sh.en_active[15:1]))
        else $error("alert raised with no enable in force");
    chk_bit0_zero: assert property (
        i_clk_en && i_reg_rd && i_reg_addr == ADDR_ALERT_SOURCE_ENABLE |=> o_reg_rdata[0] == 1'b0)
        else $error("unimplemented enable bit read as one");

    // far channels too, so the bit order is pinned at both ends of each group
    chk_overvolt_ch4_gate: assert property (
        i_clk_en && i_overvolt_event[3] |=> o_overvolt_alert[3] == $past(sh.en_active[12]))
        else $error("overvolt alert of channel 4 not gated by bit 12");
    chk_undervolt_ch1_gate: assert property (
        i_clk_en && i_undervolt_event[0] |=> o_undervolt_alert[0] == $past(sh.en_active[11]))
        else $error("undervolt alert of channel 1 not gated by bit 11");
    chk_overpower_ch4_gate: assert property (
        i_clk_en && i_overpower_event[3] |=> o_overpower_alert[3] == $past(sh.en_active[4]))
        else $error("overpower alert of channel 4 not gated by bit 4");
    chk_masked_all: assert property (
        i_clk_en && sh.en_active[15:1] == 15'h0000 |=> !o_alert_any)
        else $error("alert raised while every enable is clear");
    chk_any_is_or: assert property (
        o_alert_any == ((|o_overvolt_alert) || (|o_undervolt_alert) || (|o_overpower_alert)
            || o_accum_full_alert || o_sample_counter_full_alert || o_cycle_done_alert))
        else $error("alert any is not the or of the gated alerts");
    chk_rvalid_pulse: assert property (
        i_clk_en && !i_reg_rd |=> !o_reg_rvalid)
        else $error("read valid without a read strobe");
    chk_source_image: assert property (
        i_clk_en |=> o_accum_source_active == $past(sh.src_active))
        else $error("source image output does not follow the active copy");
    chk_enable_write: assert property (
        i_clk_en && sh.en_wr |=> sh.en_prog[0] == 1'b0 && sh.en_prog[15:1] == $past(i_reg_wdata[15:1])
            && sh.en_prog[23:16] == 8'h00)
        else $error("enable write did not land as masked");
    chk_src_refresh: assert property (
        i_clk_en && i_refresh |=> sh.src_active == $past(sh.src_prog))
        else $error("sources not activated by refresh");
    chk_clk_en_freeze: assert property (
        !i_clk_en |=> $stable(o_reg_rvalid) && $stable(o_alert_any) && $stable(o_accum_source_active)
            && $stable(sh.en_prog) && $stable(sh.src_prog) && $stable(sh.en_active))
        else $error("state moved while the clock enable was low");
endmodule

// ---- alert_host_model.sv ----
// host side of the register port: word accesses and refresh pulses
`timescale 1ns/1ps
module alert_host_model (
    input wire logic i_clk_sys,
    input wire logic [23:0] i_reg_rdata,
    input wire logic i_reg_rvalid,
    output logic o_reg_wr,
    output logic o_reg_rd,
    output logic [7:0] o_reg_addr,
    output logic [23:0] o_reg_wdata,
    output logic o_refresh
);
    initial begin
        o_reg_wr = 1'b0;
        o_reg_rd = 1'b0;
        o_reg_addr = 8'h00;
        o_reg_wdata = 24'h000000;
        o_refresh = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [23:0] d);
        @(posedge i_clk_sys);
        o_reg_wr <= 1'b1;
        o_reg_addr <= a;
        o_reg_wdata <= d;
        @(posedge i_clk_sys);
        o_reg_wr <= 1'b0;
        // released data must not keep showing the old word
        o_reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [23:0] d, output bit ok);
        ok = 1'b0;
        d = 24'h000000;
        @(posedge i_clk_sys);
        o_reg_rd <= 1'b1;
        o_reg_addr <= a;
        @(posedge i_clk_sys);
        o_reg_rd <= 1'b0;
        // rvalid rises at the edge that takes the strobe and stands one cycle only
        for (int n = 0; n < 4 && !ok; n++) begin
            #1;
            if (i_reg_rvalid === 1'b1) begin
                ok = 1'b1;
                d = i_reg_rdata;
            end else begin
                @(posedge i_clk_sys);
            end
        end
    endtask
    // every enable or source change but the first enable write is followed by one of these
    task automatic refresh();
        @(posedge i_clk_sys);
        o_refresh <= 1'b1;
        @(posedge i_clk_sys);
        o_refresh <= 1'b0;
    endtask
endmodule

// ---- alert_mask_bench.sv ----
// self-checking bench for the alert enable mask
`timescale 1ns/1ps
module alert_mask_bench;
    import alert_mask_pkg::*;
    logic i_clk_sys, i_resetn, i_clk_en, reg_wr, reg_rd, refresh, rvalid;
    logic [7:0] addr, src_act;
    logic [23:0] wdata, rdata;
    logic [3:0] ov_o, uv_o, op_o;
    logic acc_o, cnt_o, cyc_o, any_o;
    logic [15:0] ev;
    logic [15:0] seen_alerts;
    int mismatches, compares;
    // event vector laid out like the enable register, bit 15 = channel 1 overvoltage
    assign seen_alerts = {ov_o[0], ov_o[1], ov_o[2], ov_o[3], uv_o[0], uv_o[1], uv_o[2], uv_o[3],
                          op_o[0], op_o[1], op_o[2], op_o[3], acc_o, cnt_o, cyc_o, 1'b0};
    alert_mask u_dut (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_clk_en(i_clk_en),
        .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .i_reg_addr(addr), .i_reg_wdata(wdata),
        .i_refresh(refresh), .i_overvolt_event({ev[12], ev[13], ev[14], ev[15]}),
        .i_undervolt_event({ev[8], ev[9], ev[10], ev[11]}), .i_overpower_event({ev[4], ev[5], ev[6], ev[7]}),
        .i_accum_full_event(ev[3]), .i_sample_counter_full_event(ev[2]), .i_cycle_done_event(ev[1]),
        .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .o_overvolt_alert(ov_o), .o_undervolt_alert(uv_o),
        .o_overpower_alert(op_o), .o_accum_full_alert(acc_o), .o_sample_counter_full_alert(cnt_o),
        .o_cycle_done_alert(cyc_o), .o_alert_any(any_o), .o_accum_source_active(src_act));
    alert_host_model u_host (.i_clk_sys(i_clk_sys), .i_reg_rdata(rdata), .i_reg_rvalid(rvalid),
        .o_reg_wr(reg_wr), .o_reg_rd(reg_rd), .o_reg_addr(addr), .o_reg_wdata(wdata), .o_refresh(refresh));
    initial begin
        i_clk_sys = 1'b0;
        forever #10 i_clk_sys = ~i_clk_sys;
    end
    task automatic report_and_stop;
        $display("mismatches=%0d compares=%0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [23:0] exp);
        logic [23:0] d;
        bit ok;
        u_host.rd(a, d, ok);
        if (!ok) begin
            mismatches++;
            report_and_stop();
        end else begin
            check(d, exp);
        end
    endtask
    // gated alerts follow the event one cycle later, any is their or
    task automatic ev_chk(input logic [15:0] e, input logic [15:0] exp);
        @(posedge i_clk_sys);
        ev <= e;
        @(posedge i_clk_sys);
        #1;
        check({7'h00, seen_alerts, any_o}, {7'h00, exp, |exp});
    endtask
    initial begin
        ev = 16'h0000;
        i_clk_en = 1'b1;
        i_resetn = 1'b0;
        mismatches = 0;
        compares = 0;
        repeat (3) @(posedge i_clk_sys);
        i_resetn <= 1'b1;
        rd_chk(ADDR_ALERT_SOURCE_ENABLE, 24'h000000);
        rd_chk(ADDR_ACCUM_SOURCE_ACTIVE, 24'h000000);
        u_host.wr(ADDR_ALERT_SOURCE_ENABLE, 24'hffffff);
        rd_chk(ADDR_ALERT_SOURCE_ENABLE, 24'h00fffe);
        ev_chk(16'hfffe, 16'h0000);
        for (int b = 1; b < 16; b++) begin
            u_host.wr(ADDR_ALERT_SOURCE_ENABLE, 24'h000001 << b);
            u_host.refresh();
            ev_chk(16'h0001 << b, 16'h0001 << b);
            ev_chk(~(16'h0001 << b) & 16'hfffe, 16'h0000);
        end
        // clearing an enable also waits for the refresh
        u_host.wr(ADDR_ALERT_SOURCE_ENABLE, 24'h000000);
        ev_chk(16'h8000, 16'h8000);
        u_host.refresh();
        ev_chk(16'hfffe, 16'h0000);
        u_host.wr(ADDR_ACCUM_SOURCE_PROG, 24'h00001b);
        rd_chk(ADDR_ACCUM_SOURCE_ACTIVE, 24'h000000);
        check({16'h0000, src_act}, 24'h000000);
        u_host.refresh();
        rd_chk(ADDR_ACCUM_SOURCE_ACTIVE, 24'h000018);
        rd_chk(ADDR_ACCUM_SOURCE_PROG, 24'h000018);
        check({16'h0000, src_act}, 24'h000018);
        u_host.wr(ADDR_ACCUM_SOURCE_ACTIVE, 24'h0000ff);
        rd_chk(ADDR_ACCUM_SOURCE_ACTIVE, 24'h000018);
        rd_chk(8'h33, 24'h000000);
        @(posedge i_clk_sys);
        i_clk_en <= 1'b0;
        u_host.wr(ADDR_ACCUM_SOURCE_PROG, 24'h000024);
        i_clk_en <= 1'b1;
        rd_chk(ADDR_ACCUM_SOURCE_PROG, 24'h000018);
        // write, one quiet cycle, then a refresh, reserved code in channel 1
        u_host.wr(ADDR_ACCUM_SOURCE_PROG, 24'h0000e6);
        u_host.refresh();
        rd_chk(ADDR_ACCUM_SOURCE_ACTIVE, 24'h000026);
        check({16'h0000, src_act}, 24'h000026);
        report_and_stop();
    end
endmodule
